// *** pkg/csr_params.svh ***
// Constants for the card suspend and resume command handler
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
`define CSR_P1_SUSPEND 8'h00
`define CSR_P1_RESUME 8'h01
`define CSR_P1_SEL_AID 8'h04
`define CSR_LC_SUSPEND 8'h04
`define CSR_LE_SUSPEND 8'h0a
`define CSR_LC_RESUME 8'h08
`define CSR_UNIT_MAX 8'h04
`define CSR_SW_OK 16'h9000
`define CSR_SW_COND 16'h6985
`define CSR_SW_SEC 16'h6982
`define CSR_SW_MINBIG 16'h9864
`define CSR_SW_PARAM 16'h6a86
`define CSR_SW_WRONGLEN 16'h6700
`define CSR_SW_INS 16'h6d00
`define CSR_INS_SUSPEND 8'h76
`define CSR_INS_SELECT 8'ha4
`define CSR_INS_RD_BIN 8'hb0
`define CSR_INS_RD_REC 8'hb2
`define CSR_INS_TERM_CAP 8'haa
`define CSR_LFSR_SEED 64'h0123_4567_89ab_cdef
`define CSR_LFSR_TAPS 64'hd800_0000_0000_0000
`define CSR_MAX_SECS 32'd864000
`define CSR_SECS_ONE 32'd1
`define CSR_SECS_MINUTE 32'd60
`define CSR_SECS_HOUR 32'd3600
`define CSR_SECS_DAY 32'd86400
`define CSR_UNIT_SEC 8'h00
`define CSR_UNIT_MIN 8'h01
`define CSR_UNIT_HOUR 8'h02
`define CSR_UNIT_DAY 8'h03
`define CSR_P2_NONE 8'h00
`endif

// *** pkg/csr_pkg.sv ***
// Types shared by the suspend and resume handler
package csr_pkg;
  typedef struct packed {
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] lc;
    logic le_present;
    logic [7:0] le;
    logic [63:0] data;
  } csr_cmd_t;

  typedef struct packed {
    logic [7:0] unit;
    logic [7:0] count;
  } csr_dur_t;

  typedef struct packed {
    logic [15:0] sw;
    logic [3:0] rlen;
    logic [79:0] rdata;
  } csr_rsp_t;

  typedef enum logic [3:0] {
    CSR_IDLE = 4'b0001,
    CSR_EVAL = 4'b0010,
    CSR_SAVE = 4'b0100,
    CSR_DONE = 4'b1000
  } csr_state_t;
endpackage : csr_pkg

// *** rtl/csr_lfsr.sv ***
// Free-running token generator for resume tokens
`timescale 1ns/1ps
module csr_lfsr #(
  parameter int WIDTH = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] entropy,
  output logic [WIDTH-1:0] value
);
  `include "csr_params.svh"
  logic [WIDTH-1:0] lfsr_reg;
  logic [WIDTH-1:0] lfsr_next;

  // Galois step stirred with outside entropy so tokens are not a fixed sequence
  always_comb begin
    lfsr_next = {1'b0, lfsr_reg[WIDTH-1:1]} ^ entropy;
    if (lfsr_reg[0]) begin
      lfsr_next = lfsr_next ^ WIDTH'(`CSR_LFSR_TAPS);
    end
    if (lfsr_next == '0) begin
      lfsr_next = WIDTH'(`CSR_LFSR_SEED);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_reg <= WIDTH'(`CSR_LFSR_SEED);
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign value = lfsr_reg;
endmodule : csr_lfsr

// *** rtl/csr_handler.sv ***
// Suspend and resume command handler of the card
`timescale 1ns/1ps
module csr_handler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire csr_pkg::csr_cmd_t cmd,
  input wire logic proactive_active,
  input wire logic bearer_independent_channel_open,
  input wire logic secure_channel_active,
  input wire logic internal_refuse,
  input wire csr_pkg::csr_dur_t max_accept_min,
  input wire logic [63:0] entropy,
  output logic cmd_ready,
  output logic rsp_valid,
  output csr_pkg::csr_rsp_t rsp,
  output logic save_state,
  output logic restore_state,
  output logic discard_state,
  output logic suspended_pending,
  output logic handled
);
  import csr_pkg::*;
  `include "csr_params.svh"

  typedef struct packed {
    csr_state_t st;
    csr_cmd_t cmd;
    logic valid;
    logic [63:0] token;
    csr_rsp_t rsp;
    logic save;
    logic restore;
    logic discard;
    logic handled;
  } csr_regs_t;

  csr_regs_t s_reg;
  csr_regs_t s_next;
  logic [63:0] rnd;

  csr_lfsr #(
    .WIDTH(64)
  ) u_lfsr (
    .clk(clk),
    .rst_n(rst_n),
    .entropy(entropy),
    .value(rnd)
  );

  // Converts a duration to seconds so unit and count compare across units
  function automatic logic [31:0] dur_secs(input csr_dur_t d);
    logic [31:0] mult;
    mult = `CSR_SECS_ONE;
    case (d.unit)
      `CSR_UNIT_SEC: mult = `CSR_SECS_ONE;
      `CSR_UNIT_MIN: mult = `CSR_SECS_MINUTE;
      `CSR_UNIT_HOUR: mult = `CSR_SECS_HOUR;
      `CSR_UNIT_DAY: mult = `CSR_SECS_DAY;
      // Code four, and any cap unit code above four, takes this value; dmin and dmax codes above four are refused before it is used
      default: mult = `CSR_MAX_SECS;
    endcase
    dur_secs = 32'(mult * {24'h0, d.count});
  endfunction : dur_secs

  // tolerated command set
  // Tolerated commands keep a pending suspended state alive
  function automatic logic tolerated(input csr_cmd_t c);
    tolerated = (c.ins == `CSR_INS_SELECT && c.p1 != `CSR_P1_SEL_AID) ||
                c.ins == `CSR_INS_RD_BIN || c.ins == `CSR_INS_RD_REC ||
                c.ins == `CSR_INS_TERM_CAP;
  endfunction : tolerated

  csr_dur_t dmin;
  csr_dur_t dmax;
  csr_dur_t dcap;
  assign dmin = s_reg.cmd.data[63:48];
  assign dmax = s_reg.cmd.data[47:32];
  assign dcap = max_accept_min;

  always_comb begin
    s_next = s_reg;
    s_next.save = 1'b0;
    s_next.restore = 1'b0;
    s_next.discard = 1'b0;
    case (s_reg.st)
      CSR_IDLE: begin
        if (cmd_valid) begin
          s_next.cmd = cmd;
          s_next.st = CSR_EVAL;
          s_next.handled = (cmd.ins == `CSR_INS_SUSPEND);
          if (s_reg.valid && cmd.ins != `CSR_INS_SUSPEND && !tolerated(cmd)) begin
            s_next.valid = 1'b0;
            s_next.discard = 1'b1;
          end
        end
      end
      CSR_EVAL: begin
        s_next.st = CSR_DONE;
        s_next.rsp = '0;
        s_next.rsp.sw = `CSR_SW_OK;
        if (!s_reg.handled) begin
          s_next.rsp.sw = `CSR_SW_INS;
        end else if (s_reg.cmd.p1 == `CSR_P1_SUSPEND) begin
          if (s_reg.cmd.p2 != `CSR_P2_NONE) begin
            s_next.rsp.sw = `CSR_SW_PARAM;
          end else if (s_reg.cmd.lc != `CSR_LC_SUSPEND || !s_reg.cmd.le_present ||
                       s_reg.cmd.le != `CSR_LE_SUSPEND) begin
            s_next.rsp.sw = `CSR_SW_WRONGLEN;
          end else if (dmin.unit > `CSR_UNIT_MAX || dmax.unit > `CSR_UNIT_MAX ||
                       dur_secs(dmin) > dur_secs(dmax)) begin
            s_next.rsp.sw = `CSR_SW_PARAM;
          end else if (proactive_active || bearer_independent_channel_open ||
                       secure_channel_active || internal_refuse) begin
            s_next.rsp.sw = `CSR_SW_COND;
          end else if (dur_secs(dmin) > dur_secs(dcap)) begin
            s_next.rsp.sw = `CSR_SW_MINBIG;
          end else begin
            s_next.st = CSR_SAVE;
          end
        end else if (s_reg.cmd.p1 == `CSR_P1_RESUME) begin
          if (s_reg.cmd.p2 != `CSR_P2_NONE) begin
            s_next.rsp.sw = `CSR_SW_PARAM;
          end else if (s_reg.cmd.lc != `CSR_LC_RESUME || s_reg.cmd.le_present) begin
            s_next.rsp.sw = `CSR_SW_WRONGLEN;
          end else if (!s_reg.valid) begin
            s_next.rsp.sw = `CSR_SW_COND;
          end else if (s_reg.cmd.data != s_reg.token) begin
            s_next.rsp.sw = `CSR_SW_SEC;
          end else begin
            s_next.restore = 1'b1;
          end
          if (s_reg.valid) begin
            s_next.valid = 1'b0;
            s_next.discard = 1'b1;
          end
        end else begin
          s_next.rsp.sw = `CSR_SW_PARAM;
        end
      end
      CSR_SAVE: begin
        s_next.token = rnd;
        s_next.valid = 1'b1;
        s_next.save = 1'b1;
        s_next.rsp.sw = `CSR_SW_OK;
        s_next.rsp.rlen = 4'(`CSR_LE_SUSPEND);
        if (dur_secs(dmax) <= dur_secs(dcap)) begin
          s_next.rsp.rdata = {dmax, rnd};
        end else begin
          s_next.rsp.rdata = {dcap, rnd};
        end
        s_next.st = CSR_DONE;
      end
      CSR_DONE: begin
        s_next.st = CSR_IDLE;
      end
      default: begin
        s_next.st = CSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: CSR_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Only one command in flight; the terminal waits for the status word
  assign cmd_ready = (s_reg.st == CSR_IDLE);
  assign rsp_valid = (s_reg.st == CSR_DONE);
  assign rsp = s_reg.rsp;
  assign save_state = s_reg.save;
  assign restore_state = s_reg.restore;
  assign discard_state = s_reg.discard;
  assign suspended_pending = s_reg.valid;
  assign handled = s_reg.handled;
endmodule : csr_handler

// *** tb/csr_handler_sva.sv ***
// Checker for the suspend and resume handler ports
`timescale 1ns/1ps
module csr_handler_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire csr_pkg::csr_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire csr_pkg::csr_rsp_t rsp,
  input wire logic save_state,
  input wire logic restore_state,
  input wire logic discard_state,
  input wire logic suspended_pending
);
  import csr_pkg::*;
  wire take = cmd_valid && cmd_ready;
  wire res_ok = cmd.ins == 8'h76 && cmd.p1 == 8'h01 && cmd.p2 == 8'h00 && cmd.lc == 8'h08 && !cmd.le_present;
  wire tol = cmd.ins inside {8'hb0, 8'hb2, 8'haa} || (cmd.ins == 8'ha4 && cmd.p1 != 8'h04);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_save_reply_ok: assert property (save_state |-> rsp_valid && rsp.sw == 16'h9000 && rsp.rlen == 4'd10)
    else $error("suspend reply wrong");
  a_save_sets_flag: assert property (save_state |-> suspended_pending)
    else $error("flag not set on save");
  a_restore_reply: assert property (restore_state |-> rsp_valid && rsp.sw == 16'h9000 && !suspended_pending)
    else $error("restore reply wrong");
  a_discard_clears: assert property (discard_state |=> !suspended_pending)
    else $error("discard left flag set");
  a_resume_empty: assert property (take && res_ok && !suspended_pending |-> ##2 rsp_valid && rsp.sw == 16'h6985)
    else $error("empty resume not refused");
  a_resume_erase: assert property (take && res_ok |-> ##2 rsp_valid && !suspended_pending)
    else $error("resume kept state");
  a_tolerated_keep: assert property (take && tol && suspended_pending |-> ##2 suspended_pending)
    else $error("tolerated command dropped state");
  a_bad_len_no_save: assert property (take && cmd.ins == 8'h76 && cmd.p1 == 8'h00 && cmd.lc != 8'h04 |-> ##2 rsp_valid && !save_state)
    else $error("bad length suspend accepted");
  cover property (save_state);
  cover property (restore_state);
  cover property (discard_state && !restore_state);
endmodule : csr_handler_sva

bind csr_handler csr_handler_sva sva (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .save_state(save_state),
  .restore_state(restore_state), .discard_state(discard_state), .suspended_pending(suspended_pending));

// *** tb/csr_term.sv ***
// Terminal model that sends command frames and collects replies
`timescale 1ns/1ps
module csr_term (
  input wire logic clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire csr_pkg::csr_rsp_t rsp,
  output logic cmd_valid,
  output csr_pkg::csr_cmd_t cmd
);
  import csr_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  task automatic xfer(input csr_cmd_t c, output csr_rsp_t r);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = c;
    while (!cmd_ready) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    // Released lines must not look like the old frame
    cmd = ~c;
    r = '0;
    repeat (8) begin
      if (rsp_valid && r.sw == 16'h0000) r = rsp;
      @(negedge clk);
    end
  endtask : xfer
endmodule : csr_term

// *** tb/card_suspend_resume_test.sv ***
// Self-checking bench for the suspend and resume handler
`timescale 1ns/1ps
module card_suspend_resume_test;
  import csr_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic cmd_valid, cmd_ready, rsp_valid, save_state, restore_state, discard_state, suspended_pending;
  logic handled;
  logic [3:0] flg = 4'h0;
  csr_dur_t acc = '{8'h04, 8'hff};
  logic [63:0] ent = 64'h0;
  csr_cmd_t cmd;
  csr_rsp_t rsp, rs;
  logic [63:0] tok;
  int n_fail = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  always @(negedge clk) ent <= ent + 64'h3;
  csr_handler dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .proactive_active(flg[0]),
    .bearer_independent_channel_open(flg[1]), .secure_channel_active(flg[2]), .internal_refuse(flg[3]),
    .max_accept_min(acc), .entropy(ent), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .save_state(save_state), .restore_state(restore_state), .discard_state(discard_state),
    .suspended_pending(suspended_pending), .handled(handled));
  csr_term term (.clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .cmd_valid(cmd_valid),
    .cmd(cmd));
  function automatic csr_cmd_t mk(logic [7:0] i, p, l, logic e, logic [63:0] d);
    return '{i, p, 8'h00, l, e, e ? 8'h0a : 8'h00, d};
  endfunction : mk
  function automatic csr_cmd_t sus(logic [15:0] mn, mx);
    return mk(8'h76, 8'h00, 8'h04, 1'b1, {mn, mx, 32'h0});
  endfunction : sus
  task automatic chk(input logic [79:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input csr_cmd_t c);
    term.xfer(c, rs);
  endtask : go
  task automatic t_units;
    for (int u = 0; u < 5; u++) begin
      go(sus({u[7:0], 8'h01}, {u[7:0], 8'h02}));
      chk(rs.sw, 16'h9000);
      chk(rs.rdata[79:64], {u[7:0], 8'h02});
      chk(rs.rlen, 4'd10);
    end
    tok = rs.rdata[63:0];
  endtask : t_units
  task automatic t_resume_err;
    go(mk(8'h76, 8'h01, 8'h08, 1'b0, tok ^ 64'h1));
    chk(rs.sw, 16'h6982);
    chk(suspended_pending, 1'b0);
    go(mk(8'h76, 8'h01, 8'h08, 1'b0, tok));
    chk(rs.sw, 16'h6985);
  endtask : t_resume_err
  task automatic t_tolerated;
    go(mk(8'haa, 8'h00, 8'h00, 1'b0, 64'h0));
    go(sus(16'h0001, 16'h0102));
    tok = rs.rdata[63:0];
    // terminal idles while contacts are off
    repeat (4) @(negedge clk);
    chk(suspended_pending, 1'b1);
    go(mk(8'ha4, 8'h00, 8'h00, 1'b0, 64'h0));
    chk(rs.sw, 16'h6d00);
    chk(handled, 1'b0);
    go(mk(8'hb0, 8'h00, 8'h00, 1'b1, 64'h0));
    go(mk(8'hb2, 8'h00, 8'h00, 1'b1, 64'h0));
    go(mk(8'haa, 8'h00, 8'h00, 1'b0, 64'h0));
    chk(suspended_pending, 1'b1);
    go(mk(8'h76, 8'h01, 8'h08, 1'b0, tok));
    chk(rs.sw, 16'h9000);
    chk(handled, 1'b1);
    chk(suspended_pending, 1'b0);
  endtask : t_tolerated
  task automatic t_intrude;
    go(sus(16'h0001, 16'h0102));
    go(mk(8'ha4, 8'h04, 8'h00, 1'b0, 64'h0));
    chk(suspended_pending, 1'b0);
  endtask : t_intrude
  task automatic t_refuse;
    for (int k = 0; k < 4; k++) begin
      flg = 4'h1 << k;
      go(sus(16'h0001, 16'h0102));
      chk(rs.sw, 16'h6985);
    end
    flg = 4'h0;
    go(sus(16'h0501, 16'h0102));
    chk(rs.sw, 16'h6a86);
    go(mk(8'h76, 8'h00, 8'h05, 1'b1, 64'h0));
    chk(rs.sw, 16'h6700);
    go(mk(8'h76, 8'h01, 8'h08, 1'b1, 64'h0));
    chk(rs.sw, 16'h6700);
    acc = '{8'h01, 8'h0a};
    go(sus(16'h010b, 16'h0201));
    chk(rs.sw, 16'h9864);
    go(sus(16'h003c, 16'h0201));
    chk(rs.rdata[79:64], 16'h010a);
  endtask : t_refuse
  task automatic final_report;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (3) @(negedge clk);
    // Reset leaves the handler idle with no saved state
    chk({cmd_ready, rsp_valid, save_state, suspended_pending}, 4'b1000);
    rst_n = 1'b1;
    t_units();
    t_resume_err();
    t_tolerated();
    t_intrude();
    t_refuse();
    final_report();
  end
endmodule : card_suspend_resume_test
